// file: src/xfer_defs.svh
// Constants of the drive/channel transfer sequencer: register map,
// field positions, reset values, function codes and timing counts.
// Assumes inclusion by bare name from the sequencer sources.
`ifndef XFER_DEFS_SVH
`define XFER_DEFS_SVH

// Register byte offsets
`define REG_COMMAND     4'h0
`define REG_STATUS      4'h4

// Command word fields and reset value
`define CMD_FUNC_LSB    0
`define CMD_SEL_LSB     6
`define CMD_INITIAL_CW_ADDR_LSB    14
`define CMD_RESET       32'h0000_0000

// Status word bit positions
`define SB_BUSY         0
`define SB_DONE         1
`define SB_ACTIVE       2
`define SB_SEIZED       3
`define SB_ERR_LSB      4

// Function codes with the go bit set, and the drive control register
`define FUNC_WRITE_GO   6'h31
`define FUNC_READ_GO    6'h39
`define DRV_CTRL_REG    5'h00

// Timing
`define CLK_PERIOD_NS   100
`define CONTROL_BUS_TIMEOUT_TIME_NS    1500
`define CONTROL_BUS_TIMEOUT_CYCLES     (`CONTROL_BUS_TIMEOUT_TIME_NS / `CLK_PERIOD_NS)
`define DATA_BUS_TIMEOUT_TIME_MS    10
`define DATA_BUS_TIMEOUT_CYCLES     (`DATA_BUS_TIMEOUT_TIME_MS * 1000000 / `CLK_PERIOD_NS)

`endif

// file: src/xfer_pkg.sv
// Types shared by the drive/channel transfer sequencer.
// Assumes nothing of its surroundings.
package xfer_pkg;
	// Sequencer states
	typedef enum logic [2:0] {
		S_IDLE, S_SEIZE, S_WAIT_CP, S_DEMAND, S_RUN, S_XFER
	} seq_state_e;
endpackage : xfer_pkg

// file: src/link_sync.sv
// Two-flop synchroniser with edge detection for drive bus inputs.
// Assumes inputs come from outside the aclk domain.
`timescale 1ns/100ps
`default_nettype none
module link_sync #(
	parameter int W = 1
) (
	input  wire logic         aclk,    // System clock
	input  wire logic         aresetn, // Sync reset, active low
	input  wire logic [W-1:0] async_in, // Unsynchronised pins
	output logic      [W-1:0] level,   // Synchronised level
	output logic      [W-1:0] rise,    // One-cycle rising edge
	output logic      [W-1:0] fall     // One-cycle falling edge
);
	logic [W-1:0] meta_r;
	logic [W-1:0] sync_r;
	logic [W-1:0] last_r;

	if (W < 1) begin : g_bad_width
		$error("link_sync: width must be at least one");
	end

	// Per-bit chain; edge logic reads only the second and third flops
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				meta_r[i] <= 1'b0;
				sync_r[i] <= 1'b0;
				last_r[i] <= 1'b0;
			end else begin
				meta_r[i] <= async_in[i];
				sync_r[i] <= meta_r[i];
				last_r[i] <= sync_r[i];
			end
		end
	end

	// Edges
	assign level = sync_r;
	assign rise  = sync_r & ~last_r;
	assign fall  = ~sync_r & last_r;
endmodule : link_sync
`default_nettype wire

// file: src/drive_channel_transfer_sequencer.sv
// Drive/channel transfer sequencer: command load, channel seize,
// drive control cycle, run/occupied, read and write data paths.
// Assumes an AXI4-Lite master on aclk and a channel on aclk; drive
// bus pins are asynchronous and pass through link_sync.
//
// Overview of operation
// (RL1) Command write ignored while busy; else loads address, function, go, drive select.
// (RL2) Write function code with go bit is octal 61, sent in control cycle.
// (RL3) Read function code with go bit is octal 71, sent in control cycle.
// (RL4) Control cycle always targets drive register zero.
// (RL5) Supply fail, illegal function or access error at command: flag and terminate.
// (RL6) Command load sets buffered active, then active, which drives channel start.
// (RL7) Without prevent-start, set busy, assert channel start, wait for busy-in.
// (RL8) On busy-in assert seized, drive initial address, send a device pulse.
// (RL9) Channel takes count and address from control word halves.
// (RL10) Channel writes termination word on an all-zero control word.
// (RL11) Channel pulse starts demand with function and select; drive acknowledges.
// (RL12) After acknowledge assert run; drive answers with occupied.
// (RL13) Read half-words captured on the trailing edge of sync clock.
// (RL14) Check parity; first half left, second right; then assembly full.
// (RL15) Full assembly moves to channel buffer with a device pulse.
// (RL16) Channel acknowledges each read word with a channel pulse.
// (RL17) Busy-in drop clears active and start; end-of-block clears busy, sets done.
// (RL18) In a write the first channel pulse loads the channel buffer.
// (RL19) No acknowledge within timeout: control timeout, response error, done.
// (RL20) No occupied within timeout: data timeout, response error, done.
// (RL21) Write echoes sync clock as write clock, sending two halves.
// (RL22) Write sync clock with assembly empty: overrun if active, else zeros.
`timescale 1ns/100ps
`default_nettype none
`include "xfer_defs.svh"
module drive_channel_transfer_sequencer #(
	parameter int ADDR_W      = 4,            // AXI address width
	parameter int DATA_BUS_TIMEOUT_CYCLES = `DATA_BUS_TIMEOUT_CYCLES  // Data bus timeout cycles
) (
	input  wire logic              aclk,             // System clock
	input  wire logic              aresetn,          // Sync reset, low
	input  wire logic [ADDR_W-1:0] awaddr,           // Write address
	input  wire logic              awvalid,          // Write address valid
	output logic                   awready,          // Write address ready
	input  wire logic [31:0]       wdata,            // Write data
	input  wire logic [3:0]        wstrb,            // Byte strobes
	input  wire logic              wvalid,           // Write data valid
	output logic                   wready,           // Write data ready
	output logic [1:0]             bresp,            // Write response
	output logic                   bvalid,           // Response valid
	input  wire logic              bready,           // Response ready
	input  wire logic [ADDR_W-1:0] araddr,           // Read address
	input  wire logic              arvalid,          // Read address valid
	output logic                   arready,          // Read address ready
	output logic [31:0]            rdata,            // Read data
	output logic [1:0]             rresp,            // Read response
	output logic                   rvalid,           // Read data valid
	input  wire logic              rready,           // Read data ready
	input  wire logic              channel_busy_in,  // Channel seized
	input  wire logic              channel_pulse,    // Channel pulse
	input  wire logic [35:0]       channel_data_in,  // Word from channel
	output logic                   channel_start_out, // Start to channel
	output logic                   channel_seized,   // Channel held
	output logic                   device_pulse,     // Pulse to channel
	output logic [35:0]            channel_data_out, // Word to channel
	input  wire logic              drv_sclk,         // Drive sync clock
	input  wire logic              drv_transfer_ack, // Control ack
	input  wire logic              drv_occupied_ack, // Occupied
	input  wire logic              drv_end_of_block, // End of block
	input  wire logic              drv_supply_fail,  // Supply failure
	input  wire logic              drv_access_err,   // Register access err
	input  wire logic [17:0]       drv_data_in,      // Data bus in
	input  wire logic              drv_par_in,       // Parity in
	output logic [17:0]            drv_data_out,     // Data bus out
	output logic                   drv_par_out,      // Parity out
	output logic                   drv_data_oe_n,    // Data enable, low
	output logic                   control_demand,   // Demand strobe
	output logic [5:0]             drv_func,         // Function code
	output logic [2:0]             drv_select,       // Drive select
	output logic [4:0]             drv_reg_addr,     // Drive register
	output logic                   drv_run,          // Run
	output logic                   drv_wclk,         // Write clock echo
	output xfer_pkg::seq_state_e   seq_state         // Sequencer state
);
	import xfer_pkg::*;

	localparam int TMO_W = $clog2(DATA_BUS_TIMEOUT_CYCLES + 1);
	localparam logic [TMO_W-1:0] CONTROL_BUS_TIMEOUT_LAST = TMO_W'(`CONTROL_BUS_TIMEOUT_CYCLES - 1);
	localparam logic [TMO_W-1:0] DATA_BUS_TIMEOUT_LAST = TMO_W'(DATA_BUS_TIMEOUT_CYCLES - 1);
	localparam int I_PAR = 18, I_RAE = 19, I_PS = 20, I_EBL = 21;
	localparam int I_OCC = 22, I_TRA = 23, I_SCLK = 24;

	if (ADDR_W < 4 || DATA_BUS_TIMEOUT_CYCLES < `CONTROL_BUS_TIMEOUT_CYCLES || `CONTROL_BUS_TIMEOUT_CYCLES < 1)
	begin : g_bad_param
		$error("sequencer: unsupported address width or timeout");
	end

	// Register address match on word index
	function automatic logic hit(input logic [ADDR_W-1:0] a,
			input logic [3:0] off);
		return a[ADDR_W-1:2] == (ADDR_W-2)'(off[3:2]);
	endfunction : hit

	// Byte-lane merge of a write into an old value
	function automatic logic [31:0] merge(input logic [31:0] old,
			input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction : merge

	seq_state_e        state_r, state_nxt;
	logic [31:0]       command_r;
	logic              busy_r, done_r, active_buf_r, channel_active_r;
	logic              seized_r, busy_in_q_r, bvalid_r, rvalid_r;
	logic [1:0]        bresp_r, rresp_r;
	logic [31:0]       rdata_r;
	logic [7:0]        err_r;
	logic [TMO_W-1:0]  tmo_r;
	logic [17:0]       hwb_r;
	logic              hwb_par_r, hw_new_r, half_r, wclk_r;
	logic [35:0]       asm_r, cb_r;
	logic              asm_full_r, cb_full_r, dp_r;
	logic [35:0]       cdo_r;
	logic [24:0]       lvl, rise, fall;

	// Drive bus pins cross into aclk here
	link_sync #(.W(25)) u_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in ({drv_sclk, drv_transfer_ack, drv_occupied_ack,
			drv_end_of_block, drv_supply_fail, drv_access_err,
			drv_par_in, drv_data_in}),
		.level    (lvl),
		.rise     (rise),
		.fall     (fall)
	);

	// Bus decode; address and data are taken together
	wire        aw_take  = awvalid && wvalid && !bvalid_r;
	wire        ar_take  = arvalid && !rvalid_r;
	wire        wr_cmd   = aw_take && hit(awaddr, `REG_COMMAND);
	wire        wr_stat  = aw_take && hit(awaddr, `REG_STATUS);
	wire        aw_map   = hit(awaddr, `REG_COMMAND) || hit(awaddr, `REG_STATUS);
	wire        ar_cmd   = hit(araddr, `REG_COMMAND);
	wire        ar_stat  = hit(araddr, `REG_STATUS);
	wire [31:0] clr_mask = merge(32'h0, wdata, wstrb);
	wire [31:0] status_w = {20'h0, err_r, seized_r, channel_active_r,
		done_r, busy_r};

	// Command decode and prevent-start checks
	wire [31:0] cmd_new  = merge(command_r, wdata, wstrb);
	wire [5:0]  func_new = cmd_new[`CMD_FUNC_LSB +: 6];
	wire        ilf_new  = func_new != `FUNC_WRITE_GO && func_new != `FUNC_READ_GO;
	wire        cmd_load = wr_cmd && !busy_r;                    // see (RL1)
	wire        ps_bad   = cmd_load && (lvl[I_PS] || ilf_new || lvl[I_RAE]); // see (RL5)
	wire        cmd_go   = cmd_load && !ps_bad;
	wire        is_write = command_r[`CMD_FUNC_LSB +: 6] == `FUNC_WRITE_GO;
	wire [17:0] initial_cw_addr     = command_r[`CMD_INITIAL_CW_ADDR_LSB +: 18];

	// Sequencer events
	wire in_xfer   = state_r == S_XFER;
	wire seize_evt = state_r == S_SEIZE && channel_busy_in && channel_active_r; // see (RL8)
	wire tra_rise  = rise[I_TRA];
	wire control_bus_timeout_hit  = state_r == S_DEMAND && !tra_rise && tmo_r == CONTROL_BUS_TIMEOUT_LAST; // see (RL19)
	wire data_bus_timeout_hit  = state_r == S_RUN && !lvl[I_OCC] && tmo_r == DATA_BUS_TIMEOUT_LAST; // see (RL20)
	wire chan_drop = seized_r && busy_in_q_r && !channel_busy_in;    // see (RL17)
	wire ebl_end   = in_xfer && rise[I_EBL] && !channel_active_r;    // see (RL17)

	// Read path events
	wire rd_take   = in_xfer && !is_write && fall[I_SCLK];           // see (RL13)
	wire par_bad   = hw_new_r && !(^{hwb_par_r, hwb_r});             // see (RL14)
	wire rd_ovr    = hw_new_r && !half_r && asm_full_r && cb_full_r;
	wire asm_to_cb = !is_write && asm_full_r && !cb_full_r;          // see (RL15)
	wire cb_ack    = !is_write && channel_pulse && cb_full_r;

	// Write path events
	wire cb_take   = is_write && seized_r && channel_pulse;          // see (RL18)
	wire cb_to_asm = is_write && cb_full_r && !asm_full_r;
	wire wr_sclk   = in_xfer && is_write && rise[I_SCLK];            // see (RL21)
	wire wr_send   = wr_sclk && asm_full_r;
	wire wr_ovr    = wr_sclk && !asm_full_r && channel_active_r;     // see (RL22)
	wire finish    = control_bus_timeout_hit || data_bus_timeout_hit || ebl_end || wr_ovr || rd_ovr;
	wire [7:0] err_set = {par_bad, wr_ovr || rd_ovr, control_bus_timeout_hit || data_bus_timeout_hit,
		data_bus_timeout_hit, control_bus_timeout_hit, ps_bad && lvl[I_RAE], ps_bad && ilf_new,
		ps_bad && lvl[I_PS]};

	// Next state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			S_IDLE:    if (cmd_go) state_nxt = S_SEIZE;              // see (RL7)
			S_SEIZE:   if (seize_evt) state_nxt = S_WAIT_CP;
			S_WAIT_CP: if (channel_pulse) state_nxt = S_DEMAND;      // see (RL11)
			S_DEMAND:  if (tra_rise) state_nxt = S_RUN;              // see (RL12)
			S_RUN:     if (lvl[I_OCC]) state_nxt = S_XFER;
			S_XFER:    state_nxt = S_XFER;
			default:   state_nxt = S_IDLE;
		endcase
		if (finish) begin
			state_nxt = S_IDLE;
		end
	end

	// AXI4-Lite slave; unmapped words answer SLVERR
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r  <= 2'h0;
			rvalid_r <= 1'b0;
			rresp_r  <= 2'h0;
			rdata_r  <= 32'h0;
		end else begin
			bvalid_r <= aw_take || (bvalid_r && !bready);
			if (aw_take) begin
				bresp_r <= aw_map ? 2'h0 : 2'h2;
			end
			rvalid_r <= ar_take || (rvalid_r && !rready);
			if (ar_take) begin
				rresp_r <= (ar_cmd || ar_stat) ? 2'h0 : 2'h2;
				rdata_r <= ar_cmd ? command_r : (ar_stat ? status_w : 32'h0);
			end
		end
	end

	// Control state; hardware sets win over software clears
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r          <= S_IDLE;
			command_r        <= `CMD_RESET;
			busy_r           <= 1'b0;
			done_r           <= 1'b0;
			err_r            <= 8'h0;
			active_buf_r     <= 1'b0;
			channel_active_r <= 1'b0;
			seized_r         <= 1'b0;
			busy_in_q_r      <= 1'b0;
			tmo_r            <= '0;
		end else begin
			state_r   <= state_nxt;
			if (cmd_load) begin
				command_r <= cmd_new;                            // see (RL1)
			end
			busy_r       <= (busy_r && !finish) || cmd_go;        // see (RL7)
			done_r       <= (done_r && !(wr_stat && clr_mask[`SB_DONE])) ||
				finish || ps_bad;                                  // see (RL5)
			err_r        <= (err_r & ~(wr_stat ? clr_mask[`SB_ERR_LSB +: 8] :
				8'h0)) | err_set;                                  // see (RL19)
			active_buf_r <= cmd_go;                               // see (RL6)
			channel_active_r <= (channel_active_r && !chan_drop && !finish) ||
				active_buf_r;                                      // see (RL6)
			seized_r     <= (seized_r && !chan_drop && !finish) || seize_evt;
			busy_in_q_r  <= channel_busy_in;
			tmo_r        <= (state_nxt != state_r) ? '0 : tmo_r + TMO_W'(1);
		end
	end

	// Data paths for both directions
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hwb_r      <= 18'h0;
			hwb_par_r  <= 1'b0;
			hw_new_r   <= 1'b0;
			half_r     <= 1'b0;
			asm_r      <= 36'h0;
			asm_full_r <= 1'b0;
			cb_r       <= 36'h0;
			cb_full_r  <= 1'b0;
			dp_r       <= 1'b0;
			cdo_r      <= 36'h0;
			wclk_r     <= 1'b0;
		end else begin
			hw_new_r <= rd_take;
			wclk_r   <= in_xfer && is_write && lvl[I_SCLK];       // see (RL21)
			dp_r     <= seize_evt || asm_to_cb || cb_to_asm;      // see (RL8)
			if (rd_take) begin
				hwb_r     <= lvl[17:0];                           // see (RL13)
				hwb_par_r <= lvl[I_PAR];
			end else if (wr_sclk) begin
				hwb_r <= !wr_send ? 18'h0 :                       // see (RL22)
					(half_r ? asm_r[17:0] : asm_r[35:18]);         // see (RL21)
			end
			if (hw_new_r && !half_r) begin
				asm_r[35:18] <= hwb_r;                            // see (RL14)
			end else if (hw_new_r) begin
				asm_r[17:0] <= hwb_r;                             // see (RL14)
			end else if (cb_to_asm) begin
				asm_r <= cb_r;
			end
			half_r <= cmd_go || cb_to_asm ? 1'b0 :
				((hw_new_r || wr_send) ? !half_r : half_r);
			asm_full_r <= (asm_full_r && !asm_to_cb && !(wr_send && half_r) &&
				!cmd_go) || cb_to_asm || (hw_new_r && half_r);     // see (RL14)
			if (cb_take) begin
				cb_r <= channel_data_in;                          // see (RL18)
			end else if (asm_to_cb) begin
				cb_r <= asm_r;                                    // see (RL15)
			end
			cb_full_r <= (cb_full_r && !cb_to_asm && !cb_ack && !cmd_go) ||
				cb_take || asm_to_cb;                              // see (RL16)
			if (seize_evt) begin
				cdo_r <= {18'h0, initial_cw_addr};                           // see (RL8)
			end else if (asm_to_cb) begin
				cdo_r <= asm_r;                                   // see (RL15)
			end
		end
	end

	// Outputs
	assign awready           = aw_take;
	assign wready            = aw_take;
	assign bvalid            = bvalid_r;
	assign bresp             = bresp_r;
	assign arready           = ar_take;
	assign rvalid            = rvalid_r;
	assign rresp             = rresp_r;
	assign rdata             = rdata_r;
	assign channel_start_out = channel_active_r;                  // see (RL6)
	assign channel_seized    = seized_r;
	assign device_pulse      = dp_r;
	assign channel_data_out  = cdo_r;
	assign control_demand    = state_r == S_DEMAND;               // see (RL11)
	assign drv_func          = command_r[`CMD_FUNC_LSB +: 6];     // see (RL2) (RL3)
	assign drv_select        = command_r[`CMD_SEL_LSB +: 3];
	assign drv_reg_addr      = `DRV_CTRL_REG;                     // see (RL4)
	assign drv_run           = state_r == S_RUN || in_xfer;       // see (RL12)
	assign drv_wclk          = wclk_r;
	assign drv_data_out      = hwb_r;
	assign drv_par_out       = ~^hwb_r;
	assign drv_data_oe_n     = !(in_xfer && is_write);
	assign seq_state         = state_r;

	// Checks
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_busy_ignore: assert property ( // see (RL1)
		wr_cmd && busy_r |=> $stable(command_r)) else $error("command taken while busy");
	a_write_code: assert property ( // see (RL2)
		control_demand && !drv_func[3] |-> drv_func == `FUNC_WRITE_GO) else $error("bad write code");
	a_read_code: assert property ( // see (RL3)
		control_demand && !is_write |-> drv_func == `FUNC_READ_GO) else $error("bad read code");
	a_ctrl_reg: assert property ( // see (RL4)
		control_demand |-> drv_reg_addr == `DRV_CTRL_REG) else $error("demand not to reg 0");
	a_prev_start: assert property ( // see (RL5)
		ps_bad |=> done_r && !busy_r && state_r == S_IDLE) else $error("prevent-start ran");
	a_start_chain: assert property ( // see (RL6)
		cmd_go |-> ##2 channel_start_out) else $error("channel start late");
	a_busy_set: assert property ( // see (RL7)
		cmd_go |=> busy_r && state_r == S_SEIZE) else $error("busy not set");
	a_seize_pulse: assert property ( // see (RL8)
		seize_evt |=> device_pulse && channel_seized &&
		channel_data_out[17:0] == $past(initial_cw_addr)) else $error("seize pulse wrong");
	a_demand_cp: assert property ( // see (RL11)
		state_r == S_WAIT_CP && channel_pulse |=> control_demand) else $error("no demand");
	a_run_tra: assert property ( // see (RL12)
		state_r == S_DEMAND && tra_rise |=> drv_run && !control_demand) else $error("no run");
	a_read_offer: assert property ( // see (RL15)
		asm_to_cb |=> device_pulse && channel_data_out == $past(asm_r)) else $error("no offer");
	a_end_done: assert property ( // see (RL17)
		ebl_end |=> done_r && !busy_r && !drv_run) else $error("end not done");
	a_control_bus_timeout_flag: assert property ( // see (RL19)
		control_bus_timeout_hit |=> done_r && err_r[3] && err_r[5] && !busy_r) else $error("no timeout flag");
	a_overrun: assert property ( // see (RL22)
		wr_ovr |=> !channel_start_out && err_r[6] && done_r) else $error("overrun missed");
endmodule : drive_channel_transfer_sequencer
`default_nettype wire

// file: tb/drive_model.sv
// Behavioural drive on the parallel drive bus: answers demand and run,
// sends sync clocks with half-words when the bench asks for them.
// Assumes send_half and pulse_end are called from one bench process.
`timescale 1ns/100ps
`default_nettype none
module drive_model (
	input  wire logic        aclk,             // System clock
	input  wire logic        control_demand,   // Demand strobe
	input  wire logic        drv_run,          // Run
	input  wire logic        ack_en,           // Answer demand
	input  wire logic        occ_en,           // Answer run
	output logic             drv_sclk,         // Sync clock
	output logic             drv_transfer_ack, // Control ack
	output logic             drv_occupied_ack, // Occupied
	output logic             drv_end_of_block, // End of block
	output logic [17:0]      drv_data_in,      // Data lines
	output logic             drv_par_in        // Parity line
);
	// Sync clock stands still outside frames
	initial begin
		drv_sclk = 1'b0;
		drv_end_of_block = 1'b0;
		drv_data_in = 18'h0;
		drv_par_in = 1'b1;
	end
	// Ack held while demand stands; a silent drive exercises the timeouts
	always @(posedge aclk) begin
		drv_transfer_ack <= control_demand && ack_en;
		drv_occupied_ack <= drv_run && occ_en;
	end
	// One 800 ns sync clock, off phase from aclk; data from the leading edge
	task automatic send_half(input logic [17:0] h);
		#37;
		drv_data_in = h;
		drv_par_in = ~^h; // Odd parity
		drv_sclk = 1'b1;
		#400;
		drv_sclk = 1'b0;
		#400;
		// Hold time over: lines no longer show the old word
		drv_data_in = ~h;
		drv_par_in = ^h;
	endtask : send_half
	task automatic pulse_end;
		#37;
		drv_end_of_block = 1'b1;
		#800;
		drv_end_of_block = 1'b0;
	endtask : pulse_end
endmodule : drive_model
`default_nettype wire

// file: tb/drive_channel_transfer_sequencer_tb.sv
// Self-checking bench: AXI4-Lite register access, the data channel played
// here, the drive played by drive_model.
// Assumes the design sources and xfer_defs.svh are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "xfer_defs.svh"
module drive_channel_transfer_sequencer_tb;
	import xfer_pkg::*;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, channel_busy_in, channel_pulse;
	logic channel_start_out, channel_seized, device_pulse, drv_sclk;
	logic drv_transfer_ack, drv_occupied_ack, drv_end_of_block, drv_supply_fail;
	logic drv_access_err, drv_par_in, drv_par_out, drv_data_oe_n, control_demand;
	logic drv_run, drv_wclk, ack_en, occ_en;
	logic [3:0]  awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata, d, cmd;
	logic [1:0]  bresp, rresp, r;
	logic [35:0] channel_data_in, channel_data_out;
	logic [17:0] drv_data_in, drv_data_out;
	logic [5:0]  drv_func;
	logic [2:0]  drv_select;
	logic [4:0]  drv_reg_addr;
	seq_state_e  seq_state;
	int          err_total, comparisons, k;
	// Short data timeout keeps the run brief
	drive_channel_transfer_sequencer #(.DATA_BUS_TIMEOUT_CYCLES(50))
		drive_channel_transfer_sequencer_inst (.*);
	drive_model drive_model_inst (.*);
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t ns got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// Ready rises with the request and drops on the edge that raises the answer
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do @(posedge aclk); while (!(awready && wready));
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(posedge aclk); while (!bvalid);
		r = bresp;
		bready <= 1'b0;
		@(posedge aclk);
	endtask : wr
	task automatic rd(input logic [3:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask : rd
	// Channel side: answer start with busy-in, then the first channel pulse
	task automatic seize(input logic [35:0] w);
		do @(posedge aclk); while (!channel_start_out);
		channel_busy_in <= 1'b1;
		do @(posedge aclk); while (!device_pulse);
		chk(channel_seized, 1'b1);
		chk(channel_data_out[17:0], cmd[31:14]);
		channel_data_in <= w;
		channel_pulse <= 1'b1;
		@(posedge aclk);
		channel_pulse <= 1'b0;
	endtask : seize
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	// Whole sequence needs under 500 cycles; the limit of 20000 allows forty times that
	initial begin
		#2000000;
		err_total++;
		end_of_test();
	end
	initial begin
		aresetn = 1'b0;
		{awvalid, wvalid, arvalid, channel_busy_in, channel_pulse} = '0;
		{drv_supply_fail, drv_access_err, awaddr, araddr, wdata} = '0;
		{bready, rready, ack_en, occ_en} = 4'b0011;
		wstrb = 4'hf;
		channel_data_in = 36'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(`REG_COMMAND);
		chk(d, 32'h0);
		rd(4'h8);
		chk({r, d}, {2'h2, 32'h0});
		wr(4'hc, 32'h1);
		chk(r, 2'h2);
		// Supply fail, illegal function, access error each block the start
		for (k = 0; k < 3; k++) begin
			drv_supply_fail <= (k == 0);
			drv_access_err <= (k == 2);
			repeat (4) @(posedge aclk);
			wr(`REG_COMMAND, (k == 1) ? 32'h5 : 32'h39);
			rd(`REG_STATUS);
			chk(d[11:0], 12'h2 | (12'h10 << k));
			wr(`REG_STATUS, 32'hff2);
		end
		drv_supply_fail <= 1'b0;
		drv_access_err <= 1'b0;
		// Read transfer; a second command while busy must not land
		cmd = {18'h00123, 5'h0, 3'h5, 6'h39};
		repeat (4) @(posedge aclk);
		wr(`REG_COMMAND, cmd);
		wr(`REG_COMMAND, 32'h31);
		rd(`REG_COMMAND);
		chk(d, cmd);
		rd(`REG_STATUS);
		chk(d[2:0], 3'b101);
		seize(36'h0);
		do @(posedge aclk); while (!control_demand);
		chk({drv_reg_addr, drv_select, drv_func}, {5'h0, 3'h5, 6'h39});
		do @(posedge aclk); while (!drv_run);
		repeat (5) @(posedge aclk);
		fork
			begin
				drive_model_inst.send_half(18'h2aaaa);
				drive_model_inst.send_half(18'h01234);
			end
			do @(posedge aclk); while (!device_pulse);
		join
		chk(channel_data_out, {18'h2aaaa, 18'h01234});
		@(posedge aclk);
		channel_pulse <= 1'b1;
		@(posedge aclk);
		channel_pulse <= 1'b0;
		channel_busy_in <= 1'b0;
		repeat (3) @(posedge aclk);
		chk(channel_start_out, 1'b0);
		drive_model_inst.pulse_end();
		@(posedge aclk);
		rd(`REG_STATUS);
		chk({drv_run, seq_state, d[11:4], d[2:0]}, {1'b0, S_IDLE, 8'h0, 3'b010});
		wr(`REG_STATUS, 32'hff2);
		// Write transfer, then a sync clock with nothing left to send
		cmd = {18'h00200, 5'h0, 3'h2, 6'h31};
		wr(`REG_COMMAND, cmd);
		seize({18'h12345, 18'h2abcd});
		do @(posedge aclk); while (!drv_run);
		chk(drv_func, 6'h31);
		repeat (5) @(posedge aclk);
		fork
			drive_model_inst.send_half(18'h0);
			begin
				do @(posedge aclk); while (!drv_wclk);
				chk(drv_data_out, 18'h12345);
			end
		join
		chk({drv_data_oe_n, drv_par_out, drv_data_out}, {2'b00, 18'h12345});
		drive_model_inst.send_half(18'h0);
		chk(drv_data_out, 18'h2abcd);
		drive_model_inst.send_half(18'h0);
		@(posedge aclk);
		chk(channel_start_out, 1'b0);
		channel_busy_in <= 1'b0;
		rd(`REG_STATUS);
		chk({d[10], d[1:0]}, 3'b110);
		wstrb <= 4'h1;
		wr(`REG_STATUS, 32'hff2);
		rd(`REG_STATUS);
		chk({d[10], d[1]}, 2'b10);
		wstrb <= 4'hf;
		wr(`REG_STATUS, 32'hff2);
		// Channel ends early: later sync clocks get zeros, end-of-block closes
		wr(`REG_COMMAND, cmd);
		seize({18'h3ffff, 18'h3ffff});
		channel_busy_in <= 1'b0;
		do @(posedge aclk); while (!drv_run);
		repeat (5) @(posedge aclk);
		repeat (3) drive_model_inst.send_half(18'h0);
		chk(drv_data_out, 18'h0);
		drive_model_inst.pulse_end();
		rd(`REG_STATUS);
		chk({d[10], d[1:0]}, 3'b010);
		wr(`REG_STATUS, 32'hff2);
		// Silent drive: first no transfer ack, then no occupied
		for (k = 0; k < 2; k++) begin
			ack_en <= (k == 1);
			occ_en <= 1'b0;
			cmd = {18'h00300, 5'h0, 3'h7, 6'h39};
			wr(`REG_COMMAND, cmd);
			seize(36'h0);
			repeat (80) @(posedge aclk);
			rd(`REG_STATUS);
			chk({d[9:7], d[1:0]}, (k == 1) ? 5'b11010 : 5'b10110);
			channel_busy_in <= 1'b0;
			wr(`REG_STATUS, 32'hff2);
		end
		end_of_test();
	end
endmodule : drive_channel_transfer_sequencer_tb
`default_nettype wire
